/* File: mct_pkg.sv */
// Package for the match/capture timer: register map, fields, edge and action codes.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package mct_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRE_LIM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PRE_CNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MCTRL   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CCTRL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MATCH0  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAP0    = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_OUT     = 8'h38;

  localparam int unsigned N_MATCH = 4;
  localparam int unsigned N_CAP   = 2;
  localparam int unsigned N_DMA   = 2;

  // CTRL fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RST_BIT   = 1;
  localparam int unsigned CTRL_MODE_BIT  = 2;  // 0 timer, 1 counter
  localparam int unsigned CTRL_CEDGE_LSB = 3;  // 2 bits, external count edge

  // MCTRL per match: 6 bits (stop, reset, act[1:0], dma on matches 0 and 1 only, bit 5 unused)
  localparam int unsigned MC_W       = 6;
  localparam int unsigned MC_STOP    = 0;
  localparam int unsigned MC_RESET   = 1;
  localparam int unsigned MC_ACT_LSB = 2;
  localparam int unsigned MC_DMA     = 4;

  // CCTRL per capture: 2 bits edge select
  localparam int unsigned CC_W = 2;

  // STATUS/MASK layout: match events in 3:0, captures in 5:4
  localparam int unsigned ST_W       = N_MATCH + N_CAP;
  localparam int unsigned ST_CAP_LSB = N_MATCH;

  // Edge select codes
  typedef enum logic [1:0] {
    MCT_EDGE_NONE = 2'b00,
    MCT_EDGE_RISE = 2'b01,
    MCT_EDGE_FALL = 2'b10,
    MCT_EDGE_BOTH = 2'b11
  } mct_edge_type;

  // Output actions
  typedef enum logic [1:0] {
    MCT_ACT_KEEP   = 2'b00,
    MCT_ACT_LOW    = 2'b01,
    MCT_ACT_HIGH   = 2'b10,
    MCT_ACT_TOGGLE = 2'b11
  } mct_act_type;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] ONE32  = 32'h0000_0001;

endpackage : mct_pkg

/* File: mct_edge.sv */
// Edge detector: flags the chosen edge of a synchronous input.
// Assumes the input is already synchronous to clk_sys.
`timescale 1ns/100ps
module mct_edge (
  input  wire logic                  clk_sys, // System clock
  input  wire logic                  rst_b,   // Async reset, active low
  input  wire logic                  sig_in,  // Sampled input
  input  wire mct_pkg::mct_edge_type sel,     // Edge select
  output logic                       hit      // One-cycle edge pulse
);
  import mct_pkg::*;

  typedef struct packed {
    logic prev;
  } mct_edge_st_type;

  mct_edge_st_type st_reg;
  mct_edge_st_type st_next;

  ////////////////////////////////////////////////////////////////////
  // Remember last level, decode selected edge
  always_comb begin
    st_next      = st_reg;
    st_next.prev = sig_in;
    case (sel)
      MCT_EDGE_RISE: hit = sig_in & ~st_reg.prev;
      MCT_EDGE_FALL: hit = ~sig_in & st_reg.prev;
      MCT_EDGE_BOTH: hit = sig_in ^ st_reg.prev;
      default:       hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // mct_edge

/* File: mct_prescale.sv */
// Prescaler: counts enabled ticks up to a limit, then wraps and pulses.
// Assumes tick is a one-cycle enable from the timer core.
`timescale 1ns/100ps
module mct_prescale (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        rst_b,    // Async reset, active low
  input  wire logic        clr,      // Synchronous clear
  input  wire logic        tick,     // Count enable
  input  wire logic [31:0] limit,    // Wrap limit
  output logic [31:0]      count,    // Current prescale count
  output logic             wrap      // One-cycle advance pulse
);
  import mct_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
  } mct_pre_st_type;

  mct_pre_st_type st_reg;
  mct_pre_st_type st_next;

  ////////////////////////////////////////////////////////////////////
  // Wrap to zero at the limit; every wrap advances the count
  always_comb begin
    st_next = st_reg;
    wrap    = 1'b0;
    if (clr) begin
      st_next.cnt = ZERO32;
    end else if (tick) begin
      if (st_reg.cnt >= limit) begin
        st_next.cnt = ZERO32;
        wrap        = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + ONE32;
      end
    end
  end

  assign count = st_reg.cnt;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // mct_prescale

/* File: mct_timer.sv */
// Match/capture timer top: 32-bit count with prescaler, four matches,
// two captures, match outputs, DMA requests, APB register slave.
// Assumes count and capture inputs are synchronous to clk_sys.
`timescale 1ns/100ps
module mct_timer (
  input  wire logic                          clk_sys,   // System clock, 25 MHz
  input  wire logic                          rst_b,     // Async reset, active low
  input  wire logic                          psel,      // APB select
  input  wire logic                          penable,   // APB enable
  input  wire logic                          pwrite,    // APB write
  input  wire logic [mct_pkg::ADDR_W-1:0]    paddr,     // APB byte address
  input  wire logic [31:0]                   pwdata,    // APB write data
  output logic      [31:0]                   prdata,    // APB read data
  output logic                               pready,    // APB ready
  output logic                               pslverr,   // APB error
  input  wire logic                          cnt_in,    // External count input
  input  wire logic [mct_pkg::N_CAP-1:0]     cap_in,    // Capture inputs
  output logic      [mct_pkg::N_MATCH-1:0]   match_out, // Match outputs
  output logic      [mct_pkg::N_DMA-1:0]     dma_req,   // DMA request pulses
  output logic                               irq        // Interrupt level
);
  import mct_pkg::*;

  typedef struct packed {
    logic [31:0]               count;
    logic [31:0]               pre_lim;
    logic [N_MATCH*32-1:0]     match;
    logic [N_CAP*32-1:0]       cap;
    logic [N_MATCH*MC_W-1:0]   mctrl;
    logic [N_CAP*CC_W-1:0]     cctrl;
    logic                      en;
    logic                      mode;
    logic [1:0]                cedge;
    logic [ST_W-1:0]           status;
    logic [ST_W-1:0]           mask;
    logic [N_MATCH-1:0]        mout;
    logic [N_DMA-1:0]          dma;
    logic                      irq;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      err;
  } mct_st_type;

  mct_st_type st_reg;
  mct_st_type st_next;

  logic [31:0]        pre_count;
  logic               pre_wrap;
  logic               pre_clr;
  logic               tick;
  logic               cnt_edge;
  logic [N_CAP-1:0]   cap_hit;
  logic [N_MATCH-1:0] m_eq;
  logic               apb_acc;
  logic               apb_wr;

  ////////////////////////////////////////////////////////////////////
  // Edge detectors for external count and capture inputs
  mct_edge u_cnt_edge (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sig_in  (cnt_in),
    .sel     (mct_edge_type'(st_reg.cedge)),
    .hit     (cnt_edge)
  );

  generate
    for (genvar c = 0; c < N_CAP; c++) begin : g_cap
      mct_edge u_cap_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .sig_in  (cap_in[c]),
        .sel     (mct_edge_type'(st_reg.cctrl[c*CC_W +: CC_W])),
        .hit     (cap_hit[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Prescaler feeds the main count; ticks come from clock or pin
  assign tick = st_reg.en & (st_reg.mode ? cnt_edge : 1'b1);

  mct_prescale u_pre (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clr     (pre_clr),
    .tick    (tick),
    .limit   (st_reg.pre_lim),
    .count   (pre_count),
    .wrap    (pre_wrap)
  );

  // Match compare against the live count
  generate
    for (genvar m = 0; m < N_MATCH; m++) begin : g_eq
      assign m_eq[m] = (st_reg.count == st_reg.match[m*32 +: 32]);
    end
  endgenerate

  assign apb_acc = psel & penable & ~st_reg.ready;
  assign apb_wr  = apb_acc & pwrite;

  ////////////////////////////////////////////////////////////////////
  // Next-state: counting, match actions, captures, registers
  always_comb begin
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;
    logic            m_fire;
    logic            do_stop;
    logic            do_reset;
    logic [31:0]     rd;
    logic            bad;
    ev       = '0;
    w1c      = '0;
    m_fire   = 1'b0;
    do_stop  = 1'b0;
    do_reset = 1'b0;
    rd       = ZERO32;
    bad      = 1'b0;
    st_next  = st_reg;
    pre_clr  = 1'b0;
    st_next.dma = '0;

    // Matches act when the count advances while equal
    for (int m = 0; m < N_MATCH; m++) begin
      m_fire = m_eq[m] & pre_wrap;
      if (m_fire) begin
        ev[m] = 1'b1;
        if (st_reg.mctrl[m*MC_W + MC_STOP]) begin
          do_stop = 1'b1;
        end
        if (st_reg.mctrl[m*MC_W + MC_RESET]) begin
          do_reset = 1'b1;
        end
        case (mct_act_type'(st_reg.mctrl[m*MC_W + MC_ACT_LSB +: 2]))
          MCT_ACT_LOW:    st_next.mout[m] = 1'b0;
          MCT_ACT_HIGH:   st_next.mout[m] = 1'b1;
          MCT_ACT_TOGGLE: st_next.mout[m] = ~st_reg.mout[m];
          default:        st_next.mout[m] = st_reg.mout[m];
        endcase
        if (m < N_DMA) begin
          st_next.dma[m] = st_reg.mctrl[m*MC_W + MC_DMA];
        end
      end
    end

    // Count advance; reset beats plain increment, stop clears enable
    if (pre_wrap) begin
      if (do_reset) begin
        st_next.count = ZERO32;
      end else begin
        st_next.count = st_reg.count + ONE32;
      end
    end
    if (do_stop) begin
      st_next.en = 1'b0;
    end

    // Captures snapshot the count as it stands
    for (int c = 0; c < N_CAP; c++) begin
      if (cap_hit[c]) begin
        st_next.cap[c*32 +: 32] = st_reg.count;
        ev[ST_CAP_LSB + c]      = 1'b1;
      end
    end

    // APB: one wait state, answer registered
    st_next.ready = apb_acc;
    if (apb_acc) begin
      case (paddr)
        OFS_CTRL:    rd = {27'h000_0000, st_reg.cedge, st_reg.mode, 1'b0, st_reg.en};
        OFS_COUNT:   rd = st_reg.count;
        OFS_PRE_LIM: rd = st_reg.pre_lim;
        OFS_PRE_CNT: rd = pre_count;
        OFS_MCTRL:   rd = {8'h00, st_reg.mctrl};
        OFS_CCTRL:   rd = {28'h000_0000, st_reg.cctrl};
        OFS_STATUS:  rd = {26'h000_0000, st_reg.status};
        OFS_MASK:    rd = {26'h000_0000, st_reg.mask};
        OFS_OUT:     rd = {28'h000_0000, st_reg.mout};
        default: begin
          bad = 1'b1;
          for (int m = 0; m < N_MATCH; m++) begin
            if (paddr == OFS_MATCH0 + ADDR_W'(4*m)) begin
              rd  = st_reg.match[m*32 +: 32];
              bad = 1'b0;
            end
          end
          for (int c = 0; c < N_CAP; c++) begin
            if (paddr == OFS_CAP0 + ADDR_W'(4*c)) begin
              rd  = st_reg.cap[c*32 +: 32];
              bad = bad & pwrite;
            end
          end
        end
      endcase
    end
    st_next.rdata = pwrite ? ZERO32 : rd;
    st_next.err   = bad;

    // Register writes take effect in the access cycle
    if (apb_wr && !bad) begin
      case (paddr)
        OFS_CTRL: begin
          st_next.en    = pwdata[CTRL_EN_BIT];
          st_next.mode  = pwdata[CTRL_MODE_BIT];
          st_next.cedge = pwdata[CTRL_CEDGE_LSB +: 2];
          if (pwdata[CTRL_RST_BIT]) begin
            st_next.count = ZERO32;
            pre_clr       = 1'b1;
          end
        end
        OFS_COUNT:   st_next.count   = pwdata;
        OFS_PRE_LIM: st_next.pre_lim = pwdata;
        OFS_MCTRL:   st_next.mctrl   = pwdata[N_MATCH*MC_W-1:0];
        OFS_CCTRL:   st_next.cctrl   = pwdata[N_CAP*CC_W-1:0];
        OFS_STATUS:  w1c             = pwdata[ST_W-1:0];
        OFS_MASK:    st_next.mask    = pwdata[ST_W-1:0];
        OFS_OUT:     st_next.mout    = pwdata[N_MATCH-1:0];
        default: begin
          for (int m = 0; m < N_MATCH; m++) begin
            if (paddr == OFS_MATCH0 + ADDR_W'(4*m)) begin
              st_next.match[m*32 +: 32] = pwdata;
            end
          end
        end
      endcase
    end

    // Sticky status: a new event wins over a same-cycle clear
    st_next.status = (st_reg.status & ~w1c) | ev;
    st_next.irq    = |(st_next.status & st_next.mask);
  end

  ////////////////////////////////////////////////////////////////////
  // State register; every output taken from it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata    = st_reg.rdata;
  assign pready    = st_reg.ready;
  assign pslverr   = st_reg.err;
  assign match_out = st_reg.mout;
  assign dma_req   = st_reg.dma;
  assign irq       = st_reg.irq;
endmodule // mct_timer

/* File: mct_timer_properties.sv */
// Checker for the match/capture timer: APB answers, interrupt masking, DMA gating.
// Assumes it is bound to mct_timer and sees only its ports.
`timescale 1ns/100ps
module mct_timer_check import mct_pkg::*; (
  input wire logic              clk_sys, // System clock
  input wire logic              rst_b,   // Async reset, active low
  input wire logic              psel,    // APB select
  input wire logic              penable, // APB enable
  input wire logic              pwrite,  // APB write
  input wire logic [ADDR_W-1:0] paddr,   // APB address
  input wire logic [31:0]       pwdata,  // APB write data
  input wire logic [31:0]       prdata,  // APB read data
  input wire logic              pready,  // APB ready
  input wire logic              pslverr, // APB error
  input wire logic [N_DMA-1:0]  dma_req, // DMA pulses
  input wire logic              irq      // Interrupt
);
  logic            take;
  logic [ST_W-1:0] mask_sh;
  logic [11:0]     mc_sh;
  ////////////////////////////////////////////////////////////////
  // Shadow of mask and match control, taken at the APB take edge
  assign take = psel && penable && !pready;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_sh <= '0;
      mc_sh   <= '0;
    end else if (take && pwrite) begin
      if (paddr == OFS_MASK) mask_sh <= pwdata[ST_W-1:0];
      if (paddr == OFS_MCTRL) mc_sh <= pwdata[11:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // One wait state, answer one cycle long
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  apb_answer_a: assert property (take |=> pready ##1 !pready) else $error("APB answer not one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == ZERO32) else $error("read data outside answer");
  unmapped_err_a: assert property (take && paddr > OFS_OUT && paddr[1:0] == 2'h0 |=> pslverr)
    else $error("unmapped access accepted");
  cap_ro_a: assert property (take && pwrite && paddr[7:3] == OFS_CAP0[7:3] |=> pslverr)
    else $error("capture write accepted");
  // Registered irq follows a mask write on the same edge as the mask register
  irq_mask_a: assert property ((mask_sh == '0) [*2] |-> !irq)
    else $error("irq with empty mask");
  dma0_cfg_a: assert property (dma_req[0] |-> mc_sh[MC_DMA] || $past(mc_sh[MC_DMA]))
    else $error("dma 0 not enabled");
  dma1_cfg_a: assert property (dma_req[1] |-> mc_sh[MC_W+MC_DMA] || $past(mc_sh[MC_W+MC_DMA]))
    else $error("dma 1 not enabled");
endmodule // mct_timer_check

bind mct_timer mct_timer_check u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_req(dma_req), .irq(irq));

/* File: mct_far.sv */
// Far-side model: external count pulses and capture input levels.
// Assumes commands from the bench arrive synchronous to clk_sys.
`timescale 1ns/100ps
module mct_far (
  input wire logic       clk_sys, // System clock
  input wire logic       rst_b,   // Async reset, active low
  input wire logic       go,      // Start a burst of count pulses
  input wire logic [3:0] n,       // Number of rising edges
  input wire logic [1:0] cap_lvl, // Wanted capture levels
  output logic           cnt_in,  // Count line, idles low
  output logic [1:0]     cap_in   // Capture lines
);
  logic [4:0] left;
  ////////////////////////////////////////////////////////////////
  // Two toggles per pulse so the line always ends low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_in <= 1'b0;
      cap_in <= 2'h0;
      left   <= 5'h00;
    end else begin
      cap_in <= cap_lvl;
      if (go) left <= {n, 1'b0};
      else if (left != 5'h00) begin
        left   <= left - 5'h01;
        cnt_in <= ~cnt_in;
      end
    end
  end
endmodule // mct_far

/* File: mct_timer_tb.sv */
// Self-checking bench for mct_timer: APB master, far-side model, random cases.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
module mct_timer_tb;
  import mct_pkg::*;
  logic              clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, cnt_in, irq, er, cnt_go;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, seed, m, p, v;
  logic [1:0]        cap_in, cap_lvl, dma_req;
  logic [3:0]        match_out, cnt_n;
  int                bad_count, n_tests, dma_seen, dma_seen1;
  mct_timer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_in(cnt_in),
    .cap_in(cap_in), .match_out(match_out), .dma_req(dma_req), .irq(irq));
  mct_far u_far (.clk_sys(clk_sys), .rst_b(rst_b), .go(cnt_go), .n(cnt_n), .cap_lvl(cap_lvl),
    .cnt_in(cnt_in), .cap_in(cap_in));
  ////////////////////////////////////////////////////////////////
  // Clock, DMA pulse count, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (dma_req[0] === 1'b1) dma_seen++;
  always @(posedge clk_sys) if (dma_req[1] === 1'b1) dma_seen1++;
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] mc(logic stp, logic rs, mct_act_type a, logic d);
    return {1'b0, d, a, rs, stp};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen at a rising edge; only the watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rd, e); endtask
  task automatic tick(input int n); repeat (n) @(posedge clk_sys); endtask
  task automatic pulses(input logic [3:0] n);
    cnt_n <= n; cnt_go <= 1'b1; @(posedge clk_sys); cnt_go <= 1'b0; tick(2 * n + 6);
  endtask
  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'd98835; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; cap_lvl = 2'h0; cnt_go = 1'b0; cnt_n = 4'h0; bad_count = 0; n_tests = 0; dma_seen = 0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(OFS_COUNT, ZERO32); rdc(OFS_STATUS, ZERO32); chk({match_out, dma_req, irq}, 0);
    apb(1'b0, 8'h3C, 32'h0); chk({er, rd}, {1'b1, ZERO32});
    wr(OFS_CAP0, 32'h5A5A_5A5A); chk(er, 1'b1); rdc(OFS_CAP0, ZERO32);
    // Stop on one match while a continuous match toggles its output
    for (int i = 0; i < 3; i++) begin
      m = 2 + rnd() % 8; p = rnd() % 4;
      for (int j = 0; j < 4; j++) wr(8'(OFS_MATCH0 + 4 * j), 32'hFFFF_FFFF);
      wr(OFS_CTRL, 32'h0000_0002); wr(OFS_STATUS, 32'h0000_003F); wr(OFS_MASK, ZERO32);
      wr(OFS_OUT, 32'h0000_000F); wr(OFS_PRE_LIM, p); wr(OFS_MATCH0 + 8, m); wr(OFS_MATCH0 + 12, m - 1);
      wr(OFS_MCTRL, {8'h0, mc(1'b0, 1'b0, MCT_ACT_TOGGLE, 1'b0), mc(1'b1, 1'b0, MCT_ACT_LOW, 1'b0), 12'h0});
      wr(OFS_CTRL, ONE32); tick((m + 2) * (p + 1) + 8);
      rdc(OFS_COUNT, m + 1);
      rdc(OFS_CTRL, ZERO32); rdc(OFS_STATUS, 32'h0000_000C);
      chk(match_out, 4'b0011); chk(irq, 1'b0);
      wr(OFS_MASK, 32'h0000_0008); tick(2); chk(irq, 1'b1);
      wr(OFS_STATUS, 32'h0000_0008); tick(2); chk(irq, 1'b0);
    end
    // Reset, stop and keep on the same value, with both DMA pulses
    m = 2 + rnd() % 6;
    wr(OFS_CTRL, 32'h0000_0002); wr(OFS_STATUS, 32'h0000_003F); wr(OFS_OUT, 32'h0000_0004); wr(OFS_PRE_LIM, ZERO32);
    wr(OFS_MATCH0 + 8, m); wr(OFS_MATCH0 + 12, 32'hFFFF_FFFF); wr(OFS_MATCH0, m); wr(OFS_MATCH0 + 4, m);
    wr(OFS_MCTRL, {14'h0, mc(1'b0, 1'b0, MCT_ACT_KEEP, 1'b0), mc(1'b1, 1'b0, MCT_ACT_HIGH, 1'b1),
                   mc(1'b0, 1'b1, MCT_ACT_TOGGLE, 1'b1)});
    dma_seen = 0; dma_seen1 = 0; wr(OFS_CTRL, ONE32); tick(m + 10);
    rdc(OFS_COUNT, ZERO32); rdc(OFS_STATUS, 32'h0000_0007);
    chk(match_out, 4'b0111); chk(dma_seen, 1); chk(dma_seen1, 1);
    // Counter mode on rising count edges, then no edge, both edges and falling edges
    m = 1 + rnd() % 8;
    wr(OFS_CTRL, 32'h0000_0002); wr(OFS_MCTRL, ZERO32); wr(OFS_CTRL, 32'h0000_000D);
    pulses(m[3:0]); rdc(OFS_COUNT, m);
    wr(OFS_CTRL, 32'h0000_0005); pulses(m[3:0]); rdc(OFS_COUNT, m);
    wr(OFS_CTRL, 32'h0000_001D); pulses(m[3:0]); rdc(OFS_COUNT, 3 * m);
    wr(OFS_CTRL, 32'h0000_0015); pulses(m[3:0]); rdc(OFS_COUNT, 4 * m);
    // Capture: rise on channel 0, fall on 1, then both and none
    wr(OFS_CTRL, 32'h0000_0002); wr(OFS_CCTRL, 32'h0000_0009); wr(OFS_STATUS, 32'h0000_003F);
    wr(OFS_MASK, 32'h0000_0010);
    p = rnd(); wr(OFS_COUNT, p); cap_lvl <= 2'b11; tick(4);
    v = rnd(); wr(OFS_COUNT, v); cap_lvl <= 2'b00; tick(4);
    rdc(OFS_CAP0, p); rdc(OFS_CAP0 + 4, v);
    rdc(OFS_STATUS, 32'h0000_0030); chk(irq, 1'b1);
    wr(OFS_CCTRL, 32'h0000_0003); p = rnd(); wr(OFS_COUNT, p); cap_lvl <= 2'b11; tick(4);
    rdc(OFS_CAP0, p); rdc(OFS_CAP0 + 4, v);
    m = rnd(); wr(OFS_COUNT, m); cap_lvl <= 2'b00; tick(4); rdc(OFS_CAP0, m);
    results();
  end
endmodule // mct_timer_tb
